// *** tuning_decoder_consts.vh ***
`ifndef TUNING_DECODER_CONSTS_VH
`define TUNING_DECODER_CONSTS_VH

// upper opcode bits [15:10]
`define OPC_XOR_IMM        6'h0E
`define OPC_SHIFT_GROUP    6'h00
`define OPC_MOVE_IND_DEST  6'h36
`define OPC_MOVE_IND_SRC   6'h37
`define OPC_MOVE_ROW_LOCAL 6'h38
`define OPC_TEST_TRUE      6'h3C
`define OPC_TEST_FALSE     6'h3D
// shift group: middle field [9:8] and sub-code [7:4]
`define SHR_MID_FIELD      2'h0
`define SHR_SUB_CODE       4'hE
// field positions
`define OPC_HI             15
`define OPC_LO             10
`define ROW_HI             9
`define ROW_LO             8
`define COL_HI             7
`define COL_LO             4
`define LOW_HI             3
`define LOW_LO             0
// reset values and memory depth
`define CARRY_RST          1'b0
`define NIBBLE_RST         4'h0
`define MEM_WORDS          64

`endif

// *** nibble_ram.v ***
`timescale 1ns/1ps
`include "tuning_decoder_consts.vh"

// data memory: one combinational read port, one synchronous write port
module nibble_ram (
    // clock
    input  wire       sys_clk_i,
    // read port
    input  wire [5:0] rd_addr_i,
    output wire [3:0] rd_data_o,
    // write port
    input  wire       wr_en_i,
    input  wire [5:0] wr_addr_i,
    input  wire [3:0] wr_data_i
);

    reg [3:0] mem_ff [0:`MEM_WORDS-1];

    // storage write
    always @(posedge sys_clk_i) begin
        if (wr_en_i) begin
            mem_ff[wr_addr_i] <= wr_data_i;
        end
    end

    assign rd_data_o = mem_ff[rd_addr_i];

endmodule

// *** tuning_mcu_move_test_decoder.v ***
// Overview of operation
// - xor-immediate replaces the addressed nibble with its value xor the 4-bit immediate.
// - shift-right (opcode 0, middle 0 0, sub-code 1 1 1 0) rotates the register right via carry.
// - indirect-dest move copies the addressed nibble into the same row at the pointer's column.
// - indirect-src move reads the same row at the pointer's column into the addressed nibble.
// - row-local move copies a nibble from source column to destination column in one row.
// - test-true skips the next instruction when all masked bits of the nibble are one.
// - test-false skips the next instruction when all masked bits of the nibble are zero.
`timescale 1ns/1ps
`include "tuning_decoder_consts.vh"

module tuning_mcu_move_test_decoder (
    // clock and reset
    input  wire        sys_clk_i,
    input  wire        nrst_i,
    // instruction issue, one word per valid cycle
    input  wire        instr_valid_i,
    input  wire [15:0] instr_word_i,
    // debug register write port
    input  wire        reg_wr_en_i,
    input  wire [3:0]  reg_wr_addr_i,
    input  wire [3:0]  reg_wr_data_i,
    // debug memory write port
    input  wire        mem_wr_en_i,
    input  wire [5:0]  mem_wr_addr_i,
    input  wire [3:0]  mem_wr_data_i,
    // debug memory read port (data two cycles after address if no instruction executes in the second cycle)
    input  wire [5:0]  mem_rd_addr_i,
    output reg  [3:0]  mem_rd_data_o,
    // execution status
    output reg         carry_o,
    output reg         skip_pending_o,
    output reg         executed_o,
    output reg         skipped_o
);

    // general registers
    reg  [3:0] gp_reg_ff [0:15];
    reg        carry_ff;
    reg        skip_ff;
    reg        nxt_skip;
    integer    i;

    // instruction fields
    wire [5:0] opcode                 = instr_word_i[`OPC_HI:`OPC_LO];
    wire [1:0] memory_row_field       = instr_word_i[`ROW_HI:`ROW_LO];
    wire [3:0] memory_column_field    = instr_word_i[`COL_HI:`COL_LO];
    wire [3:0] low_field              = instr_word_i[`LOW_HI:`LOW_LO];
    wire [3:0] dest_column_field      = memory_column_field;
    wire [3:0] src_column_field       = low_field;
    wire [3:0] register_column_pointer = gp_reg_ff[low_field];

    // joins row and column into a memory address
    function [5:0] mem_addr;
        input [1:0] row;
        input [3:0] col;
        begin
            mem_addr = {row, col};
        end
    endfunction

    // opcode decode
    wire xor_immediate_op      = (opcode == `OPC_XOR_IMM);
    wire shift_right_carry_op  = (opcode == `OPC_SHIFT_GROUP) &&
                                 (memory_row_field == `SHR_MID_FIELD) &&
                                 (memory_column_field == `SHR_SUB_CODE);
    wire move_indirect_dest_op = (opcode == `OPC_MOVE_IND_DEST);
    wire move_indirect_src_op  = (opcode == `OPC_MOVE_IND_SRC);
    wire move_row_local_op     = (opcode == `OPC_MOVE_ROW_LOCAL);
    wire test_bits_true_op     = (opcode == `OPC_TEST_TRUE);
    wire test_bits_false_op    = (opcode == `OPC_TEST_FALSE);

    // an instruction executes only when not voided by a skip
    wire exec = instr_valid_i && !skip_ff;

    // shift operand and its value rotated right through carry
    wire       shift_now = exec && shift_right_carry_op;
    wire [3:0] shift_src = gp_reg_ff[low_field];
    wire [3:0] shift_res = {carry_ff, shift_src[3:1]};

    // true when every bit picked by the mask is one
    function masked_all_ones;
        input [3:0] value;
        input [3:0] mask;
        begin
            masked_all_ones = ((value & mask) == mask);
        end
    endfunction

    // true when every bit picked by the mask is zero
    function masked_all_zeros;
        input [3:0] value;
        input [3:0] mask;
        begin
            masked_all_zeros = ((value & mask) == 4'h0);
        end
    endfunction

    // memory port wiring
    reg  [5:0] rd_addr;
    wire [3:0] rd_data;
    reg        core_wr;
    reg  [5:0] core_wr_addr;
    reg  [3:0] core_wr_data;
    reg        dbg_rd_sel_ff;
    reg  [5:0] dbg_rd_addr_ff;

    // read address: instruction operand, or the debug address when idle
    // kept apart from the write decode so the address never waits on read data
    always @* begin
        rd_addr = mem_addr(memory_row_field, memory_column_field);
        if (exec) begin
            if (move_indirect_src_op) begin
                rd_addr = mem_addr(memory_row_field, register_column_pointer);
            end else if (move_row_local_op) begin
                rd_addr = mem_addr(memory_row_field, src_column_field);
            end
        end else if (dbg_rd_sel_ff) begin
            rd_addr = dbg_rd_addr_ff;
        end
    end

    // write target, write data and skip decision per instruction
    // moves write back the nibble read in the same cycle
    always @* begin
        core_wr      = 1'b0;
        core_wr_addr = mem_addr(memory_row_field, memory_column_field);
        core_wr_data = `NIBBLE_RST;
        nxt_skip     = 1'b0;
        if (exec) begin
            if (xor_immediate_op) begin
                core_wr      = 1'b1;
                core_wr_data = rd_data ^ low_field;
            end else if (move_indirect_dest_op) begin
                core_wr      = 1'b1;
                core_wr_addr = mem_addr(memory_row_field, register_column_pointer);
                core_wr_data = rd_data;
            end else if (move_indirect_src_op) begin
                core_wr      = 1'b1;
                core_wr_data = rd_data;
            end else if (move_row_local_op) begin
                core_wr      = 1'b1;
                core_wr_addr = mem_addr(memory_row_field, dest_column_field);
                core_wr_data = rd_data;
            end else if (test_bits_true_op) begin
                nxt_skip = masked_all_ones(rd_data, low_field);
            end else if (test_bits_false_op) begin
                nxt_skip = masked_all_zeros(rd_data, low_field);
            end
        end
    end

    // core writes take priority over debug writes
    // a debug write that meets an instruction write is lost
    wire       ram_wr      = core_wr || mem_wr_en_i;
    wire [5:0] ram_wr_addr = core_wr ? core_wr_addr : mem_wr_addr_i;
    wire [3:0] ram_wr_data = core_wr ? core_wr_data : mem_wr_data_i;

    // data memory, not cleared by reset
    nibble_ram u_ram (
        .sys_clk_i (sys_clk_i),
        .rd_addr_i (rd_addr),
        .rd_data_o (rd_data),
        .wr_en_i   (ram_wr),
        .wr_addr_i (ram_wr_addr),
        .wr_data_i (ram_wr_data)
    );

    // debug read address capture
    always @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            dbg_rd_sel_ff  <= 1'b0;
            dbg_rd_addr_ff <= 6'h00;
        end else begin
            dbg_rd_sel_ff  <= 1'b1;
            dbg_rd_addr_ff <= mem_rd_addr_i;
        end
    end

    // registers, carry and skip state
    always @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            carry_ff <= `CARRY_RST;
            skip_ff  <= 1'b0;
            for (i = 0; i < 16; i = i + 1) begin
                gp_reg_ff[i] <= `NIBBLE_RST;
            end
        end else begin
            // a debug register write in a shift cycle is dropped
            if (shift_now) begin
                gp_reg_ff[low_field] <= shift_res;
                carry_ff             <= shift_src[0];
            end else if (reg_wr_en_i) begin
                gp_reg_ff[reg_wr_addr_i] <= reg_wr_data_i;
            end
            // a skip consumes one valid slot then clears
            if (instr_valid_i) begin
                skip_ff <= nxt_skip;
            end
        end
    end

    // registered status outputs
    // carry and skip outputs show the value their state bits take at this edge
    // read data shows the debug address latched one edge earlier while idle
    always @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            mem_rd_data_o  <= `NIBBLE_RST;
            carry_o        <= `CARRY_RST;
            skip_pending_o <= 1'b0;
            executed_o     <= 1'b0;
            skipped_o      <= 1'b0;
        end else begin
            mem_rd_data_o  <= rd_data;
            carry_o        <= shift_now ? shift_src[0] : carry_ff;
            skip_pending_o <= instr_valid_i ? nxt_skip : skip_ff;
            executed_o     <= exec;
            skipped_o      <= instr_valid_i && skip_ff;
        end
    end

endmodule

// *** tuning_decoder_asserts.sv ***
`timescale 1ns/1ps
`include "tuning_decoder_consts.vh"
module tuning_decoder_asserts (
    input wire logic        sys_clk_i,
    input wire logic        nrst_i,
    input wire logic        instr_valid_i,
    input wire logic [15:0] instr_word_i,
    input wire logic        carry_o,
    input wire logic        skip_pending_o,
    input wire logic        executed_o,
    input wire logic        skipped_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    // an issued word either runs or is voided by a pending skip
    sequence s_run;  instr_valid_i && !skip_pending_o; endsequence
    sequence s_void; instr_valid_i && skip_pending_o;  endsequence
    wire is_shift = instr_word_i[15:4] == {`OPC_SHIFT_GROUP, `SHR_MID_FIELD, `SHR_SUB_CODE};
    wire is_test  = instr_word_i[15:10] == `OPC_TEST_TRUE ||
                    instr_word_i[15:10] == `OPC_TEST_FALSE;
    property p_run;   s_run |=> executed_o && !skipped_o; endproperty
    property p_void;  s_void |=> skipped_o && !executed_o && !skip_pending_o; endproperty
    property p_idle;
        !instr_valid_i |=> !executed_o && !skipped_o && $stable(skip_pending_o);
    endproperty
    property p_nontest; s_run ##0 !is_test |=> !skip_pending_o; endproperty
    property p_void_carry; s_void |=> $stable(carry_o); endproperty
    property p_carry;
        !(instr_valid_i && !skip_pending_o && is_shift) |=> $stable(carry_o);
    endproperty
    property p_pulse; executed_o |-> !skipped_o; endproperty
    property p_rst;
        disable iff (1'b0) !nrst_i |=> !executed_o && !skipped_o && !skip_pending_o && !carry_o;
    endproperty
    a_run:        assert property (p_run)        else $error("issued word did not execute");
    a_void:       assert property (p_void)       else $error("voided word not flagged");
    a_idle:       assert property (p_idle)       else $error("status moved without a word");
    a_nontest:    assert property (p_nontest)    else $error("skip armed by non-test word");
    a_void_carry: assert property (p_void_carry) else $error("voided word changed carry");
    a_carry:      assert property (p_carry)      else $error("carry changed without shift");
    a_pulse:      assert property (p_pulse)      else $error("executed and skipped together");
    a_rst:        assert property (p_rst)        else $error("status not cleared by reset");
endmodule
bind tuning_mcu_move_test_decoder tuning_decoder_asserts u_chk (.sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i), .instr_valid_i(instr_valid_i), .instr_word_i(instr_word_i),
    .carry_o(carry_o), .skip_pending_o(skip_pending_o), .executed_o(executed_o),
    .skipped_o(skipped_o));

// *** test_tuning_mcu_move_test_decoder.sv ***
`timescale 1ns/1ps
`include "tuning_decoder_consts.vh"
module test_tuning_mcu_move_test_decoder;
    reg         sys_clk_i = 1'b0;
    reg         nrst_i = 1'b0;
    reg         instr_valid_i = 1'b0;
    reg  [15:0] instr_word_i = 16'h0000;
    reg         reg_wr_en_i = 1'b0;
    reg  [3:0]  reg_wr_addr_i = 4'h0;
    reg  [3:0]  reg_wr_data_i = 4'h0;
    reg         mem_wr_en_i = 1'b0;
    reg  [5:0]  mem_wr_addr_i = 6'h00;
    reg  [3:0]  mem_wr_data_i = 4'h0;
    reg  [5:0]  mem_rd_addr_i = 6'h00;
    wire [3:0]  mem_rd_data_o;
    wire        carry_o, skip_pending_o, executed_o, skipped_o;
    reg  [3:0]  st;
    reg  [3:0]  d;
    integer     miscompares = 0;
    integer     checks_done = 0;
    // skip test words on nibble 0x5 and whether each one skips
    localparam [63:0] TWORDS = {{`OPC_TEST_TRUE, 6'h05, 4'h5}, {`OPC_TEST_TRUE, 6'h05, 4'h7},
                                {`OPC_TEST_FALSE, 6'h05, 4'hA}, {`OPC_TEST_FALSE, 6'h05, 4'h3}};
    localparam [3:0]  TSKIP = 4'b1010;
    always #4 sys_clk_i = ~sys_clk_i;
    tuning_mcu_move_test_decoder dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .instr_valid_i(instr_valid_i), .instr_word_i(instr_word_i), .reg_wr_en_i(reg_wr_en_i),
        .reg_wr_addr_i(reg_wr_addr_i), .reg_wr_data_i(reg_wr_data_i), .mem_wr_en_i(mem_wr_en_i),
        .mem_wr_addr_i(mem_wr_addr_i), .mem_wr_data_i(mem_wr_data_i),
        .mem_rd_addr_i(mem_rd_addr_i), .mem_rd_data_o(mem_rd_data_o), .carry_o(carry_o),
        .skip_pending_o(skip_pending_o), .executed_o(executed_o), .skipped_o(skipped_o));
    task step; @(negedge sys_clk_i); endtask
    task check(input string what, input [3:0] exp, input [3:0] got);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // issue one word; st = {carry, skip pending, executed, skipped} after it
    task op(input [15:0] w);
        instr_valid_i = 1'b1; instr_word_i = w; step;
        st = {carry_o, skip_pending_o, executed_o, skipped_o};
        instr_valid_i = 1'b0; step;
    endtask
    task mw(input [5:0] a, input [3:0] v);
        mem_wr_en_i = 1'b1; mem_wr_addr_i = a; mem_wr_data_i = v; step;
        mem_wr_en_i = 1'b0; step;
    endtask
    task rw(input [3:0] a, input [3:0] v);
        reg_wr_en_i = 1'b1; reg_wr_addr_i = a; reg_wr_data_i = v; step;
        reg_wr_en_i = 1'b0; step;
    endtask
    // address is latched at one edge, its data registered at the next
    task rd(input [5:0] a);
        mem_rd_addr_i = a; step; step; d = mem_rd_data_o;
    endtask
    task t_xor;
        mw(6'h15, 4'hA); op({`OPC_XOR_IMM, 6'h15, 4'h6});
        check("xor status", 4'b0010, st);
        rd(6'h15); check("xor nibble", 4'hC, d);
        $display("xor test done");
    endtask
    task t_shift_moves;
        integer i;
        rw(4'h3, 4'h6); // 0110 -> 0011 c0 -> 0001 c1 -> 1000 c1
        for (i = 0; i < 3; i = i + 1) begin
            op(16'h00E3); check("shift status", {(i > 0) ? 1'b1 : 1'b0, 3'b010}, st);
        end
        mw(6'h12, 4'h9); op({`OPC_MOVE_IND_DEST, 2'h1, 4'h2, 4'h3});
        rd(6'h18); check("ind dest", 4'h9, d);
        rw(4'h5, 4'h7); mw(6'h27, 4'h4); op({`OPC_MOVE_IND_SRC, 2'h2, 4'h1, 4'h5});
        rd(6'h21); check("ind src", 4'h4, d);
        mw(6'h32, 4'hD); op({`OPC_MOVE_ROW_LOCAL, 2'h3, 4'hE, 4'h2});
        rd(6'h3E); check("row local", 4'hD, d);
        $display("shift and move test done");
    endtask
    task t_skip;
        integer i;
        reg [3:0] e;
        reg       s;
        e = 4'h0;
        mw(6'h05, 4'h5); mw(6'h3F, 4'h0);
        for (i = 0; i < 4; i = i + 1) begin
            s = TSKIP[3-i];
            op(TWORDS[(3-i)*16 +: 16]); check("test status", {1'b1, s, 2'b10}, st);
            op({`OPC_XOR_IMM, 6'h3F, 4'hF}); check("next status", {2'b10, ~s, s}, st);
            if (!s) e = e ^ 4'hF;
            rd(6'h3F); check("next nibble", e, d);
        end
        $display("skip test done");
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (16) step;
        nrst_i = 1'b1;
        step;
        t_xor;
        t_shift_moves;
        t_skip;
        stop_test;
    end
endmodule
